// File: core/aaz_core.sv
// Auto-zero offset canceller, drift monitor and status code selection
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
// What this block does
// - Decode range field: 50,100,250,150,200,350,500 g; code 111 unused.
// - Smallest range is 0.125 g per LSB; samples clip at code limits.
// - Corner field: 00=400, 01=200, 10=100, 11=800 Hz.
// - Enable bit off means samples pass without offset subtraction.
// - One-pole low-pass estimates offset, slew limited, then subtracted.
// - Self-test phase preloads the filter with self-test zero average.
// - Fast phase: corner near 0.08 Hz, correction refreshed every 0.5 s.
// - Fast phase lasts 15 s free-running or 65535 sync periods.
// - Slow phase: corner near 0.01 Hz, refresh every 5 s, until power off.
// - With cancellation on, corrected output is limited to narrower range.
// - Drift check at update rate regardless of enable; flag excess offset.
// - Offset error is sent in every later frame until power-on reset.
// - Without state vector all errors share 0x7D or 0x1F4.
// - Error code resent every 228 us or on every sync pulse.
// - Parity failure in format bits uses an alternate frame format.
// - State vector 8-bit codes 7F,7E,7D,7C,7B,7A.
// - State vector 10-bit codes 1F9,1F8,1F7,1F6,1E7,1F4.
// - Each code only in the phases where it is valid.
// - Self-test error in normal operation means self-test circuit fault.
// - Internal mode fails under two good pulses; external passes all six.
// - Self-test zero average out of tolerance gives offset error in phase 5.
// - In reset no frames are sent and bus current stays idle.
// - In error state only error codes are sent, never samples.
module aaz_core
  import aaz_pkg::*;
#(
  parameter int          DW          = 12,
  parameter logic [11:0] SLEW_STEP   = 12'h004,
  parameter logic [11:0] OFS_MAX     = 12'h100,
  parameter logic [11:0] ZERO_TOL    = 12'h080,
  parameter logic [11:0] AZ_LIMIT    = 12'h600,
  parameter int          FAST_SHIFT  = 10,
  parameter int          SLOW_SHIFT  = 13,
  parameter longint      FRAME_C     = FRAME_CYC,
  parameter longint      FAST_UPD_C  = FAST_UPD_CYC,
  parameter longint      SLOW_UPD_C  = SLOW_UPD_CYC,
  parameter longint      FAST_LEN_C  = FAST_LEN_CYC
) (
  input  wire logic          clock,
  input  wire logic          rstn,
  input  wire logic [11:0]   paddr,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic [DW-1:0] sampleIn,
  input  wire logic          sampleValid,
  input  wire logic          syncPulse,
  input  wire logic          configDone,
  input  wire logic          configError,
  input  wire logic          stPulseDone,
  input  wire logic          stPulsePass,
  input  wire logic [DW-1:0] stZeroAvg,
  input  wire logic          parityError,
  input  wire logic          stCircuitFault,
  output logic [DW-1:0]      frameData,
  output logic               frameIsCode,
  output logic               frameAltFormat,
  output logic               frameValid,
  output logic               busIdle,
  output logic [2:0]         rangeGain,
  output logic [1:0]         filterCorner
);
  // ****************************************
  // Registers
  // ****************************************
  logic [31:0]        ctrl_ff;
  aaz_phase_e         phase_ff;
  // Accumulator is signed so the arithmetic shift keeps the sign of a falling step
  logic signed [DW+15:0] lpAcc_ff;
  logic [DW-1:0]      corr_ff;
  logic [31:0]        updCnt_ff;
  logic [31:0]        phCnt_ff;
  logic [31:0]        frmCnt_ff;
  logic [2:0]         stPass_ff;
  logic [2:0]         stCount_ff;
  logic               ofsErr_ff;
  logic               stErr_ff;
  logic               parErr_ff;
  logic               cfgErr_ff;
  logic               zeroBad_ff;
  logic [DW-1:0]      lastSample_ff;
  logic [DW-1:0]      frameData_ff;
  logic               frameIsCode_ff;
  logic               frameAlt_ff;
  logic               frameValid_ff;
  logic [31:0]        prdata_ff;
  logic               pready_ff;
  logic               pslverr_ff;

  logic               azEn;
  logic               svEn;
  logic               tenBit;
  logic               syncMode;
  logic               stInternal;
  logic               fast;
  logic               azPhase;
  logic               updTick;
  logic               sendTick;
  logic               errAny;
  logic signed [DW-1:0] lpOut;
  logic signed [DW:0] delta;
  logic [DW-1:0]      nxt_corr;
  logic signed [DW:0] corrected;
  logic [DW-1:0]      outSample;
  logic [9:0]         code;
  logic [11:0]        absCorr;
  logic [11:0]        absZero;

  assign azEn       = ctrl_ff[CTRL_AZ_EN_BIT];
  assign svEn       = ctrl_ff[CTRL_SV_BIT];
  assign tenBit     = ctrl_ff[CTRL_DW_BIT];
  assign syncMode   = ctrl_ff[CTRL_SYNC_BIT];
  assign stInternal = ctrl_ff[CTRL_STI_BIT];
  assign fast       = (phase_ff == PH_FAST);
  assign azPhase    = fast || (phase_ff == PH_SLOW);

  // ****************************************
  // APB slave
  // ****************************************
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctrl_ff <= CTRL_RESET;
    end else if (psel && penable && pwrite && paddr == CTRL_ADDR) begin
      ctrl_ff <= pwdata;
    end
  end

  // No wait states: ready follows every setup cycle, so a master never stalls
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      prdata_ff  <= 32'h0000_0000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= psel && !penable;
      pslverr_ff <= 1'b0;
      if (psel && !penable) begin
        case (paddr)
          CTRL_ADDR:   prdata_ff <= ctrl_ff;
          STATUS_ADDR: prdata_ff <= {27'h0, zeroBad_ff, cfgErr_ff, parErr_ff, stErr_ff, ofsErr_ff};
          OFFSET_ADDR: prdata_ff <= 32'(corr_ff);
          LASTTX_ADDR: prdata_ff <= {frameIsCode_ff, 15'h0, 16'(frameData_ff)};
          PHASE_ADDR:  prdata_ff <= 32'(phase_ff);
          default: begin
            prdata_ff  <= 32'h0000_0000;
            pslverr_ff <= 1'b1;
          end
        endcase
      end
    end
  end

  // ****************************************
  // Range and filter corner selection
  // ****************************************
  // Code 111 is unused; it falls back to the finest range to keep the front end defined
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rangeGain    <= 3'h0;
      filterCorner <= 2'h0;
    end else begin
      rangeGain    <= (ctrl_ff[CTRL_RG_LSB +: 3] == 3'h7) ? 3'h0 : ctrl_ff[CTRL_RG_LSB +: 3];
      filterCorner <= ctrl_ff[CTRL_FC_LSB +: 2];
    end
  end

  // ****************************************
  // Phase sequencing
  // ****************************************
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      phase_ff   <= PH_CFG;
      phCnt_ff   <= 32'h0;
      stPass_ff  <= 3'h0;
      stCount_ff <= 3'h0;
    end else begin
      case (phase_ff)
        PH_CFG:  if (configDone) phase_ff <= PH_DATA;
        // A configuration error is a dead end: the sequencer stays here and
        // repeats the configuration error code until the next power-on reset
        PH_DATA: begin
          if (!cfgErr_ff) phase_ff <= PH_ST;
        end
        PH_ST: begin
          if (stPulseDone) begin
            stCount_ff <= stCount_ff + 3'h1;
            if (stPulsePass) stPass_ff <= stPass_ff + 3'h1;
            // Internal mode may leave early on the second good pulse; external runs all six
            if ((stInternal && stPulsePass && stPass_ff == 3'h1) || stCount_ff == 3'h5) begin
              phase_ff <= azEn ? PH_FAST : PH_SLOW;
              phCnt_ff <= 32'h0;
            end
          end
        end
        PH_FAST: begin
          if (syncMode ? syncPulse : 1'b1) phCnt_ff <= phCnt_ff + 32'h1;
          if (syncMode ? (phCnt_ff == 32'(SYNC_FAST_PERIODS)) : (phCnt_ff == 32'(FAST_LEN_C - 1))) begin
            phase_ff <= PH_SLOW;
          end
        end
        PH_SLOW: phase_ff <= PH_SLOW;
        default: phase_ff <= PH_CFG;
      endcase
    end
  end

  // ****************************************
  // Auto-zero filter, slew limiter, drift monitor
  // ****************************************
  assign updTick = (phase_ff == PH_FAST || phase_ff == PH_SLOW) &&
                   (updCnt_ff == 32'(fast ? FAST_UPD_C - 1 : SLOW_UPD_C - 1));
  assign lpOut   = lpAcc_ff[DW+15:16];
  assign delta   = $signed({lpOut[DW-1], lpOut}) - $signed({corr_ff[DW-1], corr_ff});

  always_comb begin
    nxt_corr = corr_ff;
    if (delta > $signed({1'b0, SLEW_STEP[DW-1:0]})) begin
      nxt_corr = corr_ff + SLEW_STEP[DW-1:0];
    end else if (delta < -$signed({1'b0, SLEW_STEP[DW-1:0]})) begin
      nxt_corr = corr_ff - SLEW_STEP[DW-1:0];
    end else begin
      nxt_corr = lpOut;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      updCnt_ff <= 32'h0;
    end else if (updTick || !(phase_ff == PH_FAST || phase_ff == PH_SLOW)) begin
      updCnt_ff <= 32'h0;
    end else begin
      updCnt_ff <= updCnt_ff + 32'h1;
    end
  end

  // Filter state: high bits hold the estimate, low bits keep the fraction
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      lpAcc_ff <= '0;
      corr_ff  <= '0;
    end else if (phase_ff == PH_ST && stPulseDone && azEn) begin
      lpAcc_ff <= {stZeroAvg, 16'h0};
      corr_ff  <= stZeroAvg;
    end else begin
      if (sampleValid && (phase_ff == PH_FAST || phase_ff == PH_SLOW)) begin
        lpAcc_ff <= lpAcc_ff + (($signed({sampleIn, 16'h0}) - $signed(lpAcc_ff)) >>>
                    (fast ? FAST_SHIFT : SLOW_SHIFT));
      end
      if (updTick) corr_ff <= nxt_corr;
    end
  end

  // Drift is judged on the applied correction, so it runs with or without subtraction
  assign absCorr = 12'(corr_ff[DW-1] ? -corr_ff : corr_ff);
  assign absZero = 12'(stZeroAvg[DW-1] ? -stZeroAvg : stZeroAvg);

  // Error flags are sticky; only reset clears them
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ofsErr_ff  <= 1'b0;
      zeroBad_ff <= 1'b0;
      stErr_ff   <= 1'b0;
      parErr_ff  <= 1'b0;
      cfgErr_ff  <= 1'b0;
    end else begin
      if (phase_ff == PH_ST && stPulseDone && absZero > ZERO_TOL) zeroBad_ff <= 1'b1;
      if ((phase_ff == PH_SLOW && zeroBad_ff) || (updTick && absCorr > OFS_MAX)) ofsErr_ff <= 1'b1;
      if (phase_ff == PH_ST && stInternal && stPulseDone && stCount_ff == 3'h5 &&
          (stPass_ff + 3'(stPulsePass)) < 3'h2) stErr_ff <= 1'b1;
      if ((phase_ff == PH_FAST || phase_ff == PH_SLOW) && stCircuitFault) stErr_ff <= 1'b1;
      if (parityError) parErr_ff <= 1'b1;
      if (phase_ff == PH_CFG && configError) cfgErr_ff <= 1'b1;
    end
  end

  // ****************************************
  // Sample correction and limiting
  // ****************************************
  // Limiter trades headroom for a clean zero: corrected codes never reach full scale
  assign corrected = $signed({sampleIn[DW-1], sampleIn}) - $signed({corr_ff[DW-1], corr_ff});

  always_comb begin
    outSample = sampleIn;
    if (azEn) begin
      if (corrected > $signed({1'b0, AZ_LIMIT[DW-1:0]})) outSample = AZ_LIMIT[DW-1:0];
      else if (corrected < -$signed({1'b0, AZ_LIMIT[DW-1:0]})) outSample = -AZ_LIMIT[DW-1:0];
      else outSample = corrected[DW-1:0];
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) lastSample_ff <= '0;
    else if (sampleValid) lastSample_ff <= outSample;
  end

  // ****************************************
  // Code selection and frame pacing
  // ****************************************
  assign errAny = cfgErr_ff || ofsErr_ff || stErr_ff || parErr_ff;

  // Configuration error belongs to phase 2, where the sequencer holds on it
  // Parity and self-test codes are legal only in phases 4 and 5; before that
  // a pending error falls through to the not-OK code

  always_comb begin
    code = tenBit ? C10_OK : C8_OK;
    if (!svEn && errAny) begin
      code = tenBit ? C10_ERR : C8_ERR;
    end else if (cfgErr_ff && phase_ff == PH_DATA) begin
      code = tenBit ? C10_CFG : C8_CFG;
    end else if (parErr_ff && azPhase) begin
      code = tenBit ? C10_PAR : C8_PAR;
    end else if (stErr_ff && azPhase) begin
      code = tenBit ? C10_ST : C8_ST;
    end else if (ofsErr_ff && phase_ff == PH_SLOW) begin
      code = tenBit ? C10_OFS : C8_OFS;
    end else if (errAny) begin
      code = tenBit ? C10_NOK : C8_NOK;
    end
  end

  assign sendTick = (phase_ff != PH_CFG) && (syncMode ? syncPulse : (frmCnt_ff == 32'(FRAME_C - 1)));

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) frmCnt_ff <= 32'h0;
    else if (frmCnt_ff == 32'(FRAME_C - 1)) frmCnt_ff <= 32'h0;
    else frmCnt_ff <= frmCnt_ff + 32'h1;
  end

  // Reset holds all frame outputs low and the bus current at idle
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      frameData_ff   <= '0;
      frameIsCode_ff <= 1'b0;
      frameAlt_ff    <= 1'b0;
      frameValid_ff  <= 1'b0;
      busIdle        <= 1'b1;
    end else begin
      busIdle       <= 1'b0;
      frameValid_ff <= sendTick;
      if (sendTick) begin
        if (errAny || phase_ff == PH_DATA || phase_ff == PH_ST) begin
          frameData_ff   <= DW'(code);
          frameIsCode_ff <= 1'b1;
        end else begin
          frameData_ff   <= lastSample_ff;
          frameIsCode_ff <= 1'b0;
        end
        frameAlt_ff <= parErr_ff && ctrl_ff[CTRL_FMTPAR_BIT];
      end
    end
  end

  assign prdata         = prdata_ff;
  assign pready         = pready_ff;
  assign pslverr        = pslverr_ff;
  assign frameData      = frameData_ff;
  assign frameIsCode    = frameIsCode_ff;
  assign frameAltFormat = frameAlt_ff;
  assign frameValid     = frameValid_ff;
endmodule

// File: core/aaz_pkg.sv
// Package: constants for the acceleration auto-zero and error coding block
package aaz_pkg;
  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [11:0] CTRL_ADDR    = 12'h000;
  localparam logic [11:0] STATUS_ADDR  = 12'h004;
  localparam logic [11:0] OFFSET_ADDR  = 12'h008;
  localparam logic [11:0] LASTTX_ADDR  = 12'h00C;
  localparam logic [11:0] PHASE_ADDR   = 12'h010;
  // ****************************************
  // Control field positions and reset value
  // ****************************************
  localparam int CTRL_AZ_EN_BIT   = 0;
  localparam int CTRL_SV_BIT      = 1;
  localparam int CTRL_DW_BIT      = 2;
  localparam int CTRL_SYNC_BIT    = 3;
  localparam int CTRL_STI_BIT     = 4;
  localparam int CTRL_FMTPAR_BIT  = 5;
  localparam int CTRL_RG_LSB      = 8;
  localparam int CTRL_FC_LSB      = 12;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // ****************************************
  // Status and error codes
  // ****************************************
  localparam logic [9:0] C8_CFG   = 10'h07F;
  localparam logic [9:0] C8_OFS   = 10'h07E;
  localparam logic [9:0] C8_ST    = 10'h07D;
  localparam logic [9:0] C8_PAR   = 10'h07C;
  localparam logic [9:0] C8_OK    = 10'h07B;
  localparam logic [9:0] C8_NOK   = 10'h07A;
  localparam logic [9:0] C8_ERR   = 10'h07D;
  localparam logic [9:0] C10_CFG  = 10'h1F9;
  localparam logic [9:0] C10_OFS  = 10'h1F8;
  localparam logic [9:0] C10_ST   = 10'h1F7;
  localparam logic [9:0] C10_PAR  = 10'h1F6;
  localparam logic [9:0] C10_OK   = 10'h1E7;
  localparam logic [9:0] C10_NOK  = 10'h1F4;
  localparam logic [9:0] C10_ERR  = 10'h1F4;
  // ****************************************
  // Timing
  // ****************************************
  localparam longint CLK_HZ       = 250000000;
  localparam longint FRAME_NS     = 228000;
  localparam longint FAST_UPD_MS  = 500;
  localparam longint SLOW_UPD_MS  = 5000;
  localparam longint FAST_LEN_MS  = 15000;
  localparam longint FRAME_CYC    = FRAME_NS * CLK_HZ / 1000000000;
  localparam longint FAST_UPD_CYC = FAST_UPD_MS * CLK_HZ / 1000;
  localparam longint SLOW_UPD_CYC = SLOW_UPD_MS * CLK_HZ / 1000;
  localparam longint FAST_LEN_CYC = FAST_LEN_MS * CLK_HZ / 1000;
  localparam logic [15:0] SYNC_FAST_PERIODS = 16'hFFFF;
  // ****************************************
  // Phases
  // ****************************************
  typedef enum logic [4:0] {
    PH_CFG  = 5'b00001,
    PH_DATA = 5'b00010,
    PH_ST   = 5'b00100,
    PH_FAST = 5'b01000,
    PH_SLOW = 5'b10000
  } aaz_phase_e;
endpackage

// File: verification/aaz_core_chk.sv
// Port assertions for the auto-zero and error coding block
`timescale 1ns/1ps
module aaz_core_chk
  import aaz_pkg::*;
#(
  parameter int DW = 12
) (
  input wire logic          clock,
  input wire logic          rstn,
  input wire logic [11:0]   paddr,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic          pready,
  input wire logic          pslverr,
  input wire logic [DW-1:0] frameData,
  input wire logic          frameIsCode,
  input wire logic          frameAltFormat,
  input wire logic          frameValid,
  input wire logic          busIdle,
  input wire logic [2:0]    rangeGain,
  input wire logic [1:0]    filterCorner
);
  // ********
  // Helpers
  // ********
  logic isErr;
  logic isCode;
  logic ctrlWr;
  logic errSeen_ff;
  assign isErr = frameIsCode && (frameData inside {C8_CFG, C8_OFS, C8_ST, C8_PAR, C10_CFG, C10_OFS, C10_ST, C10_PAR});
  assign isCode = isErr || (frameData inside {C8_OK, C8_NOK, C10_OK, C10_NOK});
  assign ctrlWr = psel && penable && pwrite && paddr == CTRL_ADDR;
  // Sent error codes are sticky, so one seen error pins every later frame
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      errSeen_ff <= 1'b0;
    end else if (frameValid && isErr) begin
      errSeen_ff <= 1'b1;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  idle_reset_a: assert property (disable iff (1'b0) !rstn |-> busIdle && !frameValid)
    else $error("bus active in reset");
  ready_setup_a: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  ready_once_a: assert property (pready |=> !pready)
    else $error("ready held");
  slverr_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  frame_once_a: assert property (frameValid |=> !frameValid)
    else $error("frame strobe held");
  range_code_a: assert property (rangeGain != 3'b111)
    else $error("unused range code out");
  corner_write_a: assert property ($changed(filterCorner) |-> $past(ctrlWr) || $past(ctrlWr, 2))
    else $error("corner changed without write");
  alt_code_a: assert property (frameValid && frameAltFormat |-> frameIsCode)
    else $error("alternate format on a sample");
  code_set_a: assert property (frameValid && frameIsCode |-> isCode)
    else $error("unknown status code");
  sticky_err_a: assert property (errSeen_ff && frameValid |-> isErr)
    else $error("error code not repeated");
endmodule
bind aaz_core aaz_core_chk #(.DW(DW)) u_chk (.clock, .rstn, .paddr, .psel, .penable, .pwrite, .pready, .pslverr,
  .frameData, .frameIsCode, .frameAltFormat, .frameValid, .busIdle, .rangeGain, .filterCorner);

// File: verification/aaz_remote_model.sv
// Remote control module model: frame capture and sync pulse source
`timescale 1ns/1ps
module aaz_remote_model (
  input  wire logic        clock,
  input  wire logic        frameValid,
  input  wire logic        frameIsCode,
  input  wire logic        frameAltFormat,
  input  wire logic [11:0] frameData,
  input  wire logic [15:0] syncPeriod,
  output logic             syncPulse = 1'b0,
  output int               frameCount = 0,
  output logic [11:0]      lastData = 12'h000,
  output logic             lastIsCode = 1'b0,
  output logic             lastAlt = 1'b0
);
  logic [15:0] syncCnt = 16'h0000;
  // Zero period stops the source, so no stray pulse leaks between tests
  always @(posedge clock) begin
    syncCnt <= (syncPeriod == 16'h0000 || syncCnt == syncPeriod - 16'h0001) ? 16'h0000 : syncCnt + 16'h0001;
    syncPulse <= syncPeriod != 16'h0000 && syncCnt == syncPeriod - 16'h0001;
  end
  // Raw frames are kept so the receiver can judge pulse responses itself
  always @(posedge clock) begin
    if (frameValid === 1'b1) begin
      frameCount <= frameCount + 1;
      lastData <= frameData;
      lastIsCode <= frameIsCode;
      lastAlt <= frameAltFormat;
    end
  end
endmodule

// File: verification/testbench.sv
// Directed bench for the auto-zero and error coding block
`timescale 1ns/1ps
module testbench
  import aaz_pkg::*;
;
  localparam logic [31:0] AZ  = 32'h0000_0001 << CTRL_AZ_EN_BIT;
  localparam logic [31:0] SV  = 32'h0000_0001 << CTRL_SV_BIT;
  localparam logic [31:0] W10 = 32'h0000_0001 << CTRL_DW_BIT;
  localparam logic [31:0] SYN = 32'h0000_0001 << CTRL_SYNC_BIT;
  localparam logic [31:0] STI = 32'h0000_0001 << CTRL_STI_BIT;
  localparam logic [31:0] FMT = 32'h0000_0001 << CTRL_FMTPAR_BIT;
  logic        clock = 1'b0, rstn = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, stFault = 1'b0;
  logic        sampleValid = 1'b0, configDone = 1'b0, configError = 1'b0, parityError = 1'b0;
  logic        stPulseDone = 1'b0, stPulsePass = 1'b0, pready, pslverr, rerr;
  logic        frameIsCode, frameAltFormat, frameValid, busIdle, syncPulse, lastIsCode, lastAlt;
  logic [11:0] paddr = 12'h000, sampleIn = 12'h040, stZeroAvg = 12'h000, frameData, lastData;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [15:0] syncPeriod = 16'h0000;
  logic [2:0]  rangeGain;
  logic [1:0]  filterCorner;
  int          frameCount, n0, err_count = 0, check_count = 0;
  logic [31:0] stCtrl [4] = '{STI | SV | W10, STI | W10, STI, STI | SV};
  logic [11:0] stCode [4] = '{C10_ST, C10_ERR, C8_ERR, C8_ST};
  always #2 clock = ~clock;
  always @(posedge clock) sampleValid <= ~sampleValid;
  // Short counts keep the run small; expectations below use the same values
  aaz_core #(.FRAME_C(20), .FAST_UPD_C(50), .SLOW_UPD_C(100), .FAST_LEN_C(500)) DUT (
    .clock, .rstn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .sampleIn,
    .sampleValid, .syncPulse, .configDone, .configError, .stPulseDone, .stPulsePass, .stZeroAvg,
    .parityError, .stCircuitFault(stFault), .frameData, .frameIsCode, .frameAltFormat, .frameValid,
    .busIdle, .rangeGain, .filterCorner);
  aaz_remote_model u_rx (.clock, .frameValid, .frameIsCode, .frameAltFormat, .frameData, .syncPeriod,
    .syncPulse, .frameCount, .lastData, .lastIsCode, .lastAlt);
  // ********
  // Tasks
  // ********
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic start(input logic [31:0] ctrl, input logic cfgErr, input logic par, input logic [11:0] zero);
    @(posedge clock);
    rstn <= 1'b0;
    configError <= cfgErr;
    parityError <= par;
    stZeroAvg <= zero;
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    apb(1'b1, CTRL_ADDR, ctrl);
    configDone <= 1'b1;
    @(posedge clock);
    configDone <= 1'b0;
  endtask
  task automatic pulses(input logic [5:0] pat, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clock);
      stPulseDone <= 1'b1;
      stPulsePass <= pat[i];
      @(posedge clock);
      stPulseDone <= 1'b0;
    end
  endtask
  task automatic frames(input int n, input logic [11:0] code, input logic isCode, input logic alt);
    int c0;
    // Let a frame built from the old flags drain before counting
    repeat (3) @(posedge clock);
    for (int k = 0; k < n; k++) begin
      c0 = frameCount;
      for (int i = 0; i < 400 && frameCount == c0; i++) @(negedge clock);
      check("frame seen", frameCount != c0, 1'b1);
      check("frame data", lastData, code);
      check("frame kind", {lastIsCode, lastAlt}, {isCode, alt});
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #100000;
    err_count++;
    stop_test;
  end
  // ********
  // Tests
  // ********
  initial begin
    rstn <= 1'b0;
    repeat (12) @(posedge clock);
    check("idle in reset", busIdle, 1'b1);
    check("frames in reset", frameCount, 0);
    rstn <= 1'b1;
    apb(1'b0, CTRL_ADDR, 32'h0);
    check("ctrl reset", rd, CTRL_RESET);
    apb(1'b0, PHASE_ADDR, 32'h0);
    check("phase reset", rd, 32'(PH_CFG));
    apb(1'b1, STATUS_ADDR, 32'hFFFF_FFFF);
    apb(1'b0, 12'h020, 32'h0);
    check("unmapped err", rerr, 1'b1);
    check("unmapped data", rd, 32'h0);
    for (int r = 0; r < 8; r++) begin
      apb(1'b1, CTRL_ADDR, 32'(r << CTRL_RG_LSB | (r & 3) << CTRL_FC_LSB));
      repeat (3) @(posedge clock);
      check("range", rangeGain, (r == 7) ? 0 : r);
      check("corner", filterCorner, r & 3);
    end
    $display("test registers done");
    start(SV, 1'b1, 1'b0, 12'h000);
    frames(3, C8_CFG, 1'b1, 1'b0);
    for (int t = 0; t < 4; t++) begin
      start(stCtrl[t], 1'b0, 1'b0, 12'h000);
      pulses(6'h00, 6);
      frames(3, stCode[t], 1'b1, 1'b0);
    end
    for (int f = 0; f < 2; f++) begin
      start(STI | SV | (f != 0 ? FMT : 32'h0), 1'b0, 1'b1, 12'h000);
      pulses(6'h03, 2);
      frames(3, C8_PAR, 1'b1, f[0]);
    end
    start(STI | SV, 1'b0, 1'b0, 12'h100);
    pulses(6'h03, 2);
    frames(3, C8_OFS, 1'b1, 1'b0);
    apb(1'b0, STATUS_ADDR, 32'h0);
    check("zero flag", rd[4], 1'b1);
    $display("test error codes done");
    start(SYN | SV, 1'b1, 1'b0, 12'h000);
    n0 = frameCount;
    repeat (100) @(posedge clock);
    check("no free frames", frameCount - n0, 0);
    syncPeriod <= 16'h001E;
    repeat (315) @(posedge clock);
    syncPeriod <= 16'h0000;
    repeat (10) @(posedge clock);
    check("sync frames", frameCount - n0, 10);
    check("sync code", lastData, C8_CFG);
    $display("test sync done");
    start(STI | SV, 1'b0, 1'b0, 12'h000);
    frames(1, C8_OK, 1'b1, 1'b0);
    pulses(6'h03, 2);
    frames(3, 12'h040, 1'b0, 1'b0);
    @(posedge clock);
    stFault <= 1'b1;
    frames(3, C8_ST, 1'b1, 1'b0);
    stFault <= 1'b0;
    $display("test raw samples done");
    start(AZ | STI | SV, 1'b0, 1'b0, 12'h040);
    pulses(6'h03, 2);
    repeat (200) @(posedge clock);
    apb(1'b0, PHASE_ADDR, 32'h0);
    check("fast phase", rd, 32'(PH_FAST));
    repeat (600) @(posedge clock);
    apb(1'b0, PHASE_ADDR, 32'h0);
    check("slow phase", rd, 32'(PH_SLOW));
    repeat (1000) @(posedge clock);
    apb(1'b0, OFFSET_ADDR, 32'h0);
    check("offset", rd, 32'h0000_0040);
    frames(2, 12'h000, 1'b0, 1'b0);
    $display("test auto-zero done");
    stop_test;
  end
endmodule
